// File: design/spi_register_access_port.sv
// serial register access port: 40-bit datagrams, mode 3, pipelined read
// Operation
// - address byte plus four data bytes
// - bit 39 set means write
// - every reply returns previous access data
// - after a write, reply echoes write data
// - read datagram data bits are ignored
// - reply bits 39..32 carry status byte
// - status snapshot taken at each access end
// - status 7/6 right/left stop switch
// - status 5/4 position/velocity reached
// - status 3 standstill, 2 stall flag
// - status 1 driver error, 0 reset
// - register values right aligned, two's complement
// - sample rising, drive after falling, MSB first
// - extra bits emerge delayed 40 clocks
// - select rising takes last 40 bits
// - ignore bus while select high
// - clock idles high, mode 3
`include "spi_port_map.svh"
`timescale 1ns/10ps
`default_nettype none
module spi_register_access_port (
	// core clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rstn,
	// serial link pins
	input  wire logic                    sck,
	input  wire logic                    select_n,
	input  wire logic                    sdi,
	output logic                         sdoOut,
	output logic                         sdoOe,
	// command to register set
	output logic                         cmdStrobe,
	output logic                         direction_flag,
	output logic [`ADDR_BITS-1:0]        cmdAddr,
	output logic [`DATA_BITS-1:0]        cmdData,
	output logic                         cmdShort,
	// read data from register set, sampled in the cycle cmdStrobe is high
	input  wire logic [`DATA_BITS-1:0]   readData,
	// live status inputs
	input  wire logic                    stopRight,
	input  wire logic                    stopLeft,
	input  wire logic                    positionReached,
	input  wire logic                    velocityReached,
	input  wire logic                    standstill,
	input  wire logic                    stall_detect_flag,
	input  wire logic                    driverError,
	input  wire logic                    resetFlag
);
	// link domain
	logic                    linkRstn;
	logic [`FRAME_BITS-1:0]  shiftReg;
	logic                    started;
	logic                    fell;
	logic                    sdoReg;
	logic [5:0]              bitCount;
	logic                    enough;
	// core domain
	logic [`FRAME_BITS-1:0]  reply;
	logic [`DATA_BITS-1:0]   replyData;
	logic                    snapStopRight;
	logic                    snapStopLeft;
	logic                    snapPosReached;
	logic                    snapVelReached;
	logic                    snapStandstill;
	logic                    snapStall;
	logic                    snapDrvError;
	logic                    snapResetFlag;
	logic [`SYNC_STAGES-1:0] selSync;
	logic                    selState;
	logic                    selAgree;
	logic                    selRise;
	logic                    takeCmd;
	spi_port_pkg::port_state_t state;
	spi_port_pkg::port_state_t next_state;

	// only the frame-start marks and the sdo register are cleared by a high select; the shift
	// register and the bit count keep the frame for the core to read
	assign linkRstn = rstn & ~select_n;

	always_ff @(posedge sck or negedge linkRstn) begin
		if (!linkRstn) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end

	// stray clocks while deselected must not disturb the frozen frame
	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			shiftReg <= '0;
		end else if (!select_n) begin
			if (started) begin
				shiftReg <= {shiftReg[`FRAME_BITS-2:0], sdi};
			end else begin
				shiftReg <= {reply[`FRAME_BITS-2:0], sdi};
			end
		end
	end

	// a frame with no clock at all leaves the old count and bits in place
	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			bitCount <= '0;
		end else if (!select_n) begin
			if (!started) begin
				bitCount <= 6'h01;
			end else if (!enough) begin
				bitCount <= bitCount + 6'h01;
			end
		end
	end

	assign enough = (bitCount == 6'(`FRAME_BITS));

	always_ff @(negedge sck or negedge linkRstn) begin
		if (!linkRstn) begin
			sdoReg <= 1'b0;
		end else begin
			sdoReg <= shiftReg[`FRAME_BITS-1];
		end
	end

	always_ff @(negedge sck or negedge linkRstn) begin
		if (!linkRstn) begin
			fell <= 1'b0;
		end else begin
			fell <= started;
		end
	end

	// first bit must stand before the first falling edge of the bus clock
	assign sdoOut = fell ? sdoReg : reply[`FRAME_BITS-1];
	assign sdoOe  = ~select_n;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			selSync <= {`SYNC_STAGES{1'b1}};
		end else begin
			selSync <= {selSync[`SYNC_STAGES-2:0], select_n};
		end
	end

	// a level change counts only once the last two stages agree
	assign selAgree = (selSync[1] == selSync[2]);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			selState <= 1'b1;
		end else if (selAgree) begin
			selState <= selSync[2];
		end
	end

	assign selRise = selAgree & selSync[2] & ~selState;
	assign takeCmd = (state == spi_port_pkg::PORT_IDLE) & selRise;

	// a select rise during the two-cycle command sequence is lost
	always_comb begin
		next_state = state;
		unique case (state)
			spi_port_pkg::PORT_IDLE: begin
				if (selRise) begin
					next_state = spi_port_pkg::PORT_CMD;
				end
			end
			spi_port_pkg::PORT_CMD: begin
				next_state = spi_port_pkg::PORT_REPLY;
			end
			spi_port_pkg::PORT_REPLY: begin
				next_state = spi_port_pkg::PORT_IDLE;
			end
			default: begin
				next_state = spi_port_pkg::PORT_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= spi_port_pkg::PORT_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// the link is still while select is high, so its bits are steady here
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmdStrobe <= 1'b0;
		end else begin
			cmdStrobe <= takeCmd;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			direction_flag <= 1'b0;
		end else if (takeCmd) begin
			direction_flag <= shiftReg[`DIR_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmdAddr <= '0;
		end else if (takeCmd) begin
			cmdAddr <= shiftReg[`ADDR_MSB:`ADDR_LSB];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmdData <= '0;
		end else if (takeCmd) begin
			cmdData <= shiftReg[`DATA_BITS-1:0];
		end
	end

	// short frames are flagged rather than dropped
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmdShort <= 1'b0;
		end else if (takeCmd) begin
			cmdShort <= ~enough;
		end
	end

	// the status snapshot is taken at the end of each access
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			snapStopRight <= 1'b0;
		end else if (state == spi_port_pkg::PORT_CMD) begin
			snapStopRight <= stopRight;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			snapStopLeft <= 1'b0;
		end else if (state == spi_port_pkg::PORT_CMD) begin
			snapStopLeft <= stopLeft;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			snapPosReached <= 1'b0;
		end else if (state == spi_port_pkg::PORT_CMD) begin
			snapPosReached <= positionReached;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			snapVelReached <= 1'b0;
		end else if (state == spi_port_pkg::PORT_CMD) begin
			snapVelReached <= velocityReached;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			snapStandstill <= 1'b0;
		end else if (state == spi_port_pkg::PORT_CMD) begin
			snapStandstill <= standstill;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			snapStall <= 1'b0;
		end else if (state == spi_port_pkg::PORT_CMD) begin
			snapStall <= stall_detect_flag;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			snapDrvError <= 1'b0;
		end else if (state == spi_port_pkg::PORT_CMD) begin
			snapDrvError <= driverError;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			snapResetFlag <= 1'b0;
		end else if (state == spi_port_pkg::PORT_CMD) begin
			snapResetFlag <= resetFlag;
		end
	end

	// a write is echoed, a read returns the word the register set presents
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			replyData <= '0;
		end else if (state == spi_port_pkg::PORT_CMD) begin
			if (direction_flag) begin
				replyData <= cmdData;
			end else begin
				replyData <= readData;
			end
		end
	end

	// status byte on top, right switch first, data word below
	assign reply = {snapStopRight, snapStopLeft, snapPosReached, snapVelReached,
		snapStandstill, snapStall, snapDrvError, snapResetFlag, replyData};
endmodule
`default_nettype wire

// File: design/spi_port_map.svh
// offsets, field positions and sizes of the serial register port
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH
`define FRAME_BITS       40
`define DATA_BITS        32
`define ADDR_BITS        7
`define DIR_BIT          39
`define STATUS_MSB       39
`define STATUS_LSB       32
`define ADDR_MSB         38
`define ADDR_LSB         32
`define WRITE_ADDR_OFFS  8'h80
`define ST_STOP_RIGHT    7
`define ST_STOP_LEFT     6
`define ST_POS_REACHED   5
`define ST_VEL_REACHED   4
`define ST_STANDSTILL    3
`define ST_STALL         2
`define ST_DRV_ERROR     1
`define ST_RESET_FLAG    0
`define SYNC_STAGES      3
`endif

// File: design/spi_port_pkg.sv
// types of the serial register port
package spi_port_pkg;
	typedef enum logic [1:0] {
		PORT_IDLE,
		PORT_CMD,
		PORT_REPLY
	} port_state_t;
endpackage

// File: test/spi_register_access_port_properties.sv
// port timing properties
`timescale 1ns/10ps
`default_nettype none
module spi_register_access_port_properties (
	input wire logic        core_clk, rstn, select_n, sdoOe, cmdStrobe,
	input wire logic        direction_flag,
	input wire logic [6:0]  cmdAddr,
	input wire logic [31:0] cmdData
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	chk_oe_select: assert property (sdoOe == !select_n)
		else $error("oe wrong");
	chk_strobe_pulse: assert property (cmdStrobe |=> !cmdStrobe)
		else $error("strobe long");
	chk_strobe_due: assert property ($rose(select_n) |-> ##[1:6] cmdStrobe)
		else $error("no strobe");
	chk_strobe_sync: assert property ($rose(select_n) |-> !cmdStrobe ##1 !cmdStrobe)
		else $error("strobe early");
	chk_idle_selected: assert property (!select_n |-> !cmdStrobe)
		else $error("strobe in frame");
	chk_strobe_high: assert property (cmdStrobe |-> $past(select_n, 2))
		else $error("strobe cause");
	chk_cmd_holds: assert property (!cmdStrobe |-> $stable({direction_flag, cmdAddr, cmdData}))
		else $error("cmd moved");
	chk_reset_zero: assert property ($rose(rstn) |-> !cmdStrobe && cmdData == 0)
		else $error("reset value");
endmodule
bind spi_register_access_port spi_register_access_port_properties chk (
	.core_clk(core_clk), .rstn(rstn), .select_n(select_n), .sdoOe(sdoOe),
	.cmdStrobe(cmdStrobe), .direction_flag(direction_flag),
	.cmdAddr(cmdAddr), .cmdData(cmdData));
`default_nettype wire

// File: test/spi_host_model.sv
// mode 3 host master on the link
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
	// link
	output logic      sck,
	output logic      select_n,
	output logic      sdi,
	input  wire logic sdo
);
	initial begin
		sck = 1;
		select_n = 1;
		sdi = 0;
	end
	task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
		select_n = 0;
		#20;
		for (int i = n - 1; i >= 0; i--) begin
			sck = 0;
			sdi = tx[i];
			#15;
			rx = {rx[46:0], sdo};
			sck = 1;
			#15;
		end
		#10;
		select_n = 1;
		sdi = ~sdi;  // inverted line, no stale value
		#40;
	endtask
endmodule
`default_nettype wire

// File: test/spi_register_access_port_test.sv
// port bench
`timescale 1ns/10ps
`default_nettype none
module spi_register_access_port_test;
	logic        core_clk = 0, rstn = 0, sdoOut, sdoOe, cmdStrobe, cmdShort;
	logic        direction_flag, sck, select_n, sdi;
	logic [6:0]  cmdAddr;
	logic [31:0] cmdData, readData = 0, mem [128];
	logic [7:0]  st = 0;
	logic [47:0] rx;
	int          err_count = 0, samples_checked = 0, cyc = 0;
	initial forever #2 core_clk = ~core_clk;
	spi_host_model host (.sck(sck), .select_n(select_n), .sdi(sdi), .sdo(sdoOut));
	spi_register_access_port uut (.core_clk(core_clk), .rstn(rstn), .sck(sck),
		.select_n(select_n), .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe),
		.cmdStrobe(cmdStrobe), .direction_flag(direction_flag),
		.cmdAddr(cmdAddr), .cmdData(cmdData), .cmdShort(cmdShort),
		.readData(readData), .stopRight(st[7]), .stopLeft(st[6]),
		.positionReached(st[5]), .velocityReached(st[4]), .standstill(st[3]),
		.stall_detect_flag(st[2]), .driverError(st[1]), .resetFlag(st[0]));
	always @(negedge core_clk) begin
		if (cmdStrobe && direction_flag) mem[cmdAddr] <= cmdData;
		readData <= mem[cmdAddr];
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [47:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		mem[7'h21] = 32'h1234_5678;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk) rstn = 1;
		repeat (4) @(negedge core_clk);
		st = 8'h5A;
		host.xfer(48'h21_0000_0000, 40, rx);
		chk("first", rx[39:0], 0);
		@(negedge core_clk) st = 8'hA5;
		host.xfer(48'hA7_00AB_CDEF, 40, rx);
		chk("piped", rx[39:0], 40'h5A_1234_5678);
		chk("wcmd", {direction_flag, cmdAddr, cmdData}, 40'hA7_00AB_CDEF);
		host.xfer(48'h27_FFFF_FFFF, 40, rx);
		chk("echo", rx[39:0], 40'hA5_00AB_CDEF);
		host.xfer(48'hC3_27_0000_0000, 48, rx);
		chk("dummy", rx[47:8], 40'hA5_00AB_CDEF);
		chk("chain", rx[7:0], 8'hC3);
		chk("last40", {cmdShort, direction_flag, cmdAddr}, 9'h027);
		test_done();
	end
endmodule
`default_nettype wire
